/* File: status_reporter_pkg.sv */
// status_reporter_pkg: offsets, layout, codes and counts of the status reporter
// assumes a 50 MHz clock and a plain address/strobe register port
package status_reporter_pkg;
  // register port widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  // word offsets on the register port
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_XFER_COUNT = 8'h10;
  localparam logic [7:0] OFS_LIVE = 8'h14;
  localparam logic [7:0] OFS_RECORD = 8'h80;
  // command codes written to the command register
  localparam logic [1:0] CMD_STATUS = 2'h1;
  localparam logic [1:0] CMD_REQUEST = 2'h2;
  localparam logic [1:0] CMD_STOP = 2'h3;
  // bus address field
  localparam logic [4:0] ADDR_MAX = 5'h1E;
  localparam logic [4:0] ADDR_RST = 5'h00;
  // interrupt bit positions
  localparam int unsigned IRQ_CHANGE = 0;
  localparam int unsigned IRQ_SRQ = 1;
  localparam int unsigned IRQ_TRIG = 2;
  localparam int unsigned IRQ_CLEAR = 3;
  localparam int unsigned IRQ_STOP = 4;
  localparam int unsigned IRQ_W = 5;
  localparam logic [4:0] IRQ_RST = 5'h00;
  // record columns (1-based)
  localparam logic [6:0] COL_MODE = 7'h01;
  localparam logic [6:0] COL_ADDR = 7'h03;
  localparam logic [6:0] COL_CHANGE = 7'h06;
  localparam logic [6:0] COL_STATE = 7'h09;
  localparam logic [6:0] COL_SRQ = 7'h0B;
  localparam logic [6:0] COL_ERR = 7'h0E;
  localparam logic [6:0] COL_TRIG = 7'h12;
  localparam logic [6:0] COL_CLEAR = 7'h15;
  localparam logic [6:0] COL_XFER = 7'h18;
  localparam logic [6:0] COL_TEXT = 7'h1B;
  localparam logic [6:0] TEXT_LEN = 7'h2D;
  localparam logic [6:0] REC_LEN = 7'h47;
  localparam logic [6:0] MSG_LEN = 7'h08;
  // window after a serial poll before a still-held request counts again
  localparam int unsigned REARM_NS = 1000;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned REARM_CYC = REARM_NS * CLK_MHZ / 1000;
  localparam logic [7:0] REARM_CNT = 8'(REARM_CYC);
endpackage

/* File: status_string_reporter.sv */
// status_string_reporter: builds the fixed-column status record, keeps the
// flags it reports and halts a continuous dma transfer on the stop command
// assumes bus-side logic on clk gives pulses; only the srq line is a raw pin
//
// Function
// - column 1 shows C as active controller, P as peripheral.
// - bus address shown as two decimal digits, limited to 00..30.
// - G1 after a talker/listener/controller state change, cleared by status read.
// - state column shows T talking, L listening, I idle.
// - service request field reads S1 when internal flag set, S0 otherwise.
// - controller role: flag follows srq line, serial poll clears it.
// - peripheral role: request command sets flag, serial poll clears it.
// - column 14 holds E and two digit error number, 00 no error.
// - column 18 T1 after peripheral receives bus trigger, else T0.
// - trigger and clear flags frozen during continuous dma transfers.
// - column 24 P0 idle, P1 continuous dma, P2 autoreload dma.
// - column 27 carries 45 columns of message text for the error.
// - stop command halts a running continuous dma transfer.
// - stop after the continuous transfer finished does nothing.
// - count of characters moved before stop is kept for later query.
// - request still held by another device after poll sets flag again.
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
module status_string_reporter (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [status_reporter_pkg::ADDR_W-1:0] addr,
  input wire logic [status_reporter_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [status_reporter_pkg::DATA_W-1:0] rdata,
  // bus state from the interface logic
  input wire logic ctrl_active,
  input wire logic talking,
  input wire logic listening,
  input wire logic srq_pin,
  input wire logic serial_poll_done,
  input wire logic trigger_rcvd,
  input wire logic clear_rcvd,
  // error code from the command interpreter
  input wire logic [6:0] error_code,
  // dma engine
  input wire logic dma_busy,
  input wire logic autoreload_dma_mode,
  input wire logic [15:0] dma_count,
  output logic dma_stop,
  // requesting service and interrupt
  output logic srq_request,
  output logic irq
);
  import status_reporter_pkg::*;

  // two-digit decimal of a value below 100, as ascii
  function automatic logic [15:0] dec2(input logic [6:0] v);
    logic [6:0] t;
    logic [6:0] o;
    t = v / 7'd10;
    o = v - 7'(t * 7'd10);
    dec2 = {8'h30 + {1'b0, t}, 8'h30 + {1'b0, o}};
  endfunction

  // flag pair such as S0/S1
  function automatic logic [15:0] flag2(input logic [7:0] ch, input logic f);
    flag2 = {ch, f ? 8'h31 : 8'h30};
  endfunction

  // one column of the message text, padded with spaces
  function automatic logic [7:0] msg_char(input logic [6:0] code, input logic [6:0] i);
    logic [63:0] s;
    s = (code == 7'h00) ? "NO ERROR" : "ERROR   ";
    msg_char = (i < MSG_LEN) ? s[8'(63 - 8 * i) -: 8] : 8'h20;
  endfunction

  // register port decode
  wire logic wr_ctrl = wr && (addr == OFS_CTRL);
  wire logic wr_cmd = wr && (addr == OFS_CMD);
  wire logic wr_stat = wr && (addr == OFS_IRQ_STAT);
  wire logic wr_mask = wr && (addr == OFS_IRQ_MASK);
  wire logic cmd_status = wr_cmd && (wdata[1:0] == CMD_STATUS);
  wire logic cmd_request = wr_cmd && (wdata[1:0] == CMD_REQUEST);
  wire logic cmd_stop = wr_cmd && (wdata[1:0] == CMD_STOP);

  // srq pin synchroniser and edge detect on the second stage
  logic srq_s1_r;
  logic srq_s2_r;
  logic srq_d_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      srq_s1_r <= 1'b0;
      srq_s2_r <= 1'b0;
      srq_d_r <= 1'b0;
    end else begin
      srq_s1_r <= srq_pin;
      srq_s2_r <= srq_s1_r;
      srq_d_r <= srq_s2_r;
    end
  end
  wire logic srq_rise = srq_s2_r && !srq_d_r;

  // addressed state code and change detect
  wire logic [1:0] st_now = talking ? 2'd1 : (listening ? 2'd2 : 2'd0);
  wire logic [2:0] addr_state = {ctrl_active, st_now};
  logic [2:0] addr_state_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_state_r <= 3'h0;
    end else begin
      addr_state_r <= addr_state;
    end
  end
  wire logic change_evt = (addr_state != addr_state_r);

  // control register: own bus address, clamped at the top value
  logic [4:0] bus_addr_r;
  wire logic [4:0] bus_addr_nxt = (wdata[4:0] > ADDR_MAX) ? ADDR_MAX : wdata[4:0];
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_addr_r <= ADDR_RST;
    end else if (wr_ctrl) begin
      bus_addr_r <= bus_addr_nxt;
    end
  end

  // continuous transfer running: trigger and clear indications frozen
  wire logic cont_busy = dma_busy && !autoreload_dma_mode;
  wire logic trig_evt = trigger_rcvd && !ctrl_active && !cont_busy;
  wire logic clr_evt = clear_rcvd && !ctrl_active && !cont_busy;
  // a status read during a continuous run must not clear them either
  wire logic flag_clr = cmd_status && !cont_busy;

  // sticky flags; a new event wins over the clear by status read
  logic change_r;
  logic trig_r;
  logic clr_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      change_r <= 1'b0;
      trig_r <= 1'b0;
      clr_r <= 1'b0;
    end else begin
      change_r <= change_evt || (change_r && !cmd_status);
      trig_r <= trig_evt || (trig_r && !flag_clr);
      clr_r <= clr_evt || (clr_r && !flag_clr);
    end
  end

  // rearm counter: after a poll, a line still held past the window sets again
  logic [7:0] rearm_r;
  wire logic rearm_end = (rearm_r == 8'h01) && srq_s2_r && ctrl_active;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rearm_r <= 8'h00;
    end else if (serial_poll_done) begin
      rearm_r <= REARM_CNT;
    end else if (rearm_r != 8'h00) begin
      rearm_r <= rearm_r - 8'h01;
    end
  end

  // internal service request flag
  wire logic srq_set_ctl = ctrl_active && (srq_rise || rearm_end);
  wire logic srq_set_per = !ctrl_active && cmd_request;
  wire logic srq_set = srq_set_ctl || srq_set_per;
  logic srq_flag_r;
  wire logic srq_flag_nxt = srq_set || (srq_flag_r && !serial_poll_done);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      srq_flag_r <= 1'b0;
    end else begin
      srq_flag_r <= srq_flag_nxt;
    end
  end

  // service request pin copy, registered so the output comes from a flop;
  // it follows a role change one cycle late
  logic srq_req_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      srq_req_r <= 1'b0;
    end else begin
      srq_req_r <= srq_flag_nxt && !ctrl_active;
    end
  end

  // stop command: only a running continuous transfer is halted
  wire logic stop_take = cmd_stop && cont_busy;
  logic dma_stop_r;
  logic [15:0] xfer_count_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dma_stop_r <= 1'b0;
      xfer_count_r <= 16'h0000;
    end else begin
      dma_stop_r <= stop_take;
      if (stop_take) begin
        xfer_count_r <= dma_count;
      end
    end
  end

  // transfer status code
  wire logic [1:0] xfer_code = !dma_busy ? 2'd0 : (autoreload_dma_mode ? 2'd2 : 2'd1);

  // snapshot of every field, taken by the status command
  logic snap_ctl_r;
  logic [4:0] snap_addr_r;
  logic snap_change_r;
  logic [1:0] snap_state_r;
  logic snap_srq_r;
  logic [6:0] snap_err_r;
  logic snap_trig_r;
  logic snap_clr_r;
  logic [1:0] snap_xfer_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      snap_ctl_r <= 1'b0;
      snap_addr_r <= ADDR_RST;
      snap_change_r <= 1'b0;
      snap_state_r <= 2'd0;
      snap_srq_r <= 1'b0;
      snap_err_r <= 7'h00;
      snap_trig_r <= 1'b0;
      snap_clr_r <= 1'b0;
      snap_xfer_r <= 2'd0;
    end else if (cmd_status) begin
      snap_ctl_r <= ctrl_active;
      snap_addr_r <= bus_addr_r;
      snap_change_r <= change_r || change_evt;
      snap_state_r <= st_now;
      snap_srq_r <= srq_flag_r;
      snap_err_r <= (error_code > 7'd99) ? 7'd99 : error_code;
      snap_trig_r <= trig_r || trig_evt;
      snap_clr_r <= clr_r || clr_evt;
      snap_xfer_r <= xfer_code;
    end
  end

  // field text of the snapshot
  wire logic [7:0] ch_mode = snap_ctl_r ? "C" : "P";
  wire logic [15:0] ch_addr = dec2({2'b00, snap_addr_r});
  wire logic [15:0] ch_change = flag2("G", snap_change_r);
  wire logic [7:0] ch_state = (snap_state_r == 2'd1) ? "T" :
                              ((snap_state_r == 2'd2) ? "L" : "I");
  wire logic [15:0] ch_srq = flag2("S", snap_srq_r);
  wire logic [15:0] ch_err = dec2(snap_err_r);
  wire logic [15:0] ch_trig = flag2("T", snap_trig_r);
  wire logic [15:0] ch_clr = flag2("C", snap_clr_r);
  wire logic [15:0] ch_xfer = {8'h50, 8'h30 + {6'h00, snap_xfer_r}};

  // character at a record column; gaps and tail are spaces
  wire logic [6:0] col = addr[6:0];
  wire logic [6:0] txt_i = col - COL_TEXT;
  logic [7:0] rec_char;
  always_comb begin
    rec_char = 8'h20;
    if (col == COL_MODE) begin
      rec_char = ch_mode;
    end else if (col == COL_ADDR) begin
      rec_char = ch_addr[15:8];
    end else if (col == COL_ADDR + 7'd1) begin
      rec_char = ch_addr[7:0];
    end else if (col == COL_CHANGE) begin
      rec_char = ch_change[15:8];
    end else if (col == COL_CHANGE + 7'd1) begin
      rec_char = ch_change[7:0];
    end else if (col == COL_STATE) begin
      rec_char = ch_state;
    end else if (col == COL_SRQ) begin
      rec_char = ch_srq[15:8];
    end else if (col == COL_SRQ + 7'd1) begin
      rec_char = ch_srq[7:0];
    end else if (col == COL_ERR) begin
      rec_char = "E";
    end else if (col == COL_ERR + 7'd1) begin
      rec_char = ch_err[15:8];
    end else if (col == COL_ERR + 7'd2) begin
      rec_char = ch_err[7:0];
    end else if (col == COL_TRIG) begin
      rec_char = ch_trig[15:8];
    end else if (col == COL_TRIG + 7'd1) begin
      rec_char = ch_trig[7:0];
    end else if (col == COL_CLEAR) begin
      rec_char = ch_clr[15:8];
    end else if (col == COL_CLEAR + 7'd1) begin
      rec_char = ch_clr[7:0];
    end else if (col == COL_XFER) begin
      rec_char = ch_xfer[15:8];
    end else if (col == COL_XFER + 7'd1) begin
      rec_char = ch_xfer[7:0];
    end else if (col >= COL_TEXT && txt_i < TEXT_LEN) begin
      rec_char = msg_char(snap_err_r, txt_i);
    end
  end

  // interrupt status (write one to clear, set wins) and mask
  wire logic [IRQ_W-1:0] irq_evt = {stop_take, clr_evt, trig_evt, srq_set, change_evt};
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic irq_r;
  wire logic [IRQ_W-1:0] irq_clr = wr_stat ? wdata[IRQ_W-1:0] : '0;
  wire logic [IRQ_W-1:0] irq_stat_nxt = irq_evt | (irq_stat_r & ~irq_clr);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat_r <= IRQ_RST;
      irq_mask_r <= IRQ_RST;
      irq_r <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_r <= |(irq_stat_nxt & (wr_mask ? wdata[IRQ_W-1:0] : irq_mask_r));
      if (wr_mask) begin
        irq_mask_r <= wdata[IRQ_W-1:0];
      end
    end
  end

  // read data mux, registered one cycle after the strobe
  wire logic in_rec = (addr >= OFS_RECORD + 8'h01) && (addr <= OFS_RECORD + {1'b0, REC_LEN});
  wire logic [15:0] live = {8'h00, xfer_code, srq_flag_r, clr_r, trig_r, change_r, st_now};
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (in_rec) begin
      rd_mux = {8'h00, rec_char};
    end else if (addr == OFS_CTRL) begin
      rd_mux = {11'h000, bus_addr_r};
    end else if (addr == OFS_IRQ_STAT) begin
      rd_mux = {11'h000, irq_stat_r};
    end else if (addr == OFS_IRQ_MASK) begin
      rd_mux = {11'h000, irq_mask_r};
    end else if (addr == OFS_XFER_COUNT) begin
      rd_mux = xfer_count_r;
    end else if (addr == OFS_LIVE) begin
      rd_mux = live;
    end
  end
  logic [15:0] rdata_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rd ? rd_mux : 16'h0000;
    end
  end

  // outputs straight from flip-flops
  assign rdata = rdata_r;
  assign dma_stop = dma_stop_r;
  assign srq_request = srq_req_r;
  assign irq = irq_r;
endmodule // status_string_reporter

/* File: status_reporter_monitor.sv */
// status_reporter_monitor: port-level checks of the status reporter
// assumes one clock domain on clk and the bind at the foot of this file
`timescale 1ns/1ns
module status_reporter_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [status_reporter_pkg::ADDR_W-1:0] addr,
  input wire logic [status_reporter_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [status_reporter_pkg::DATA_W-1:0] rdata,
  // role, dma and service request
  input wire logic ctrl_active,
  input wire logic dma_busy,
  input wire logic autoreload_dma_mode,
  input wire logic dma_stop,
  input wire logic srq_request,
  input wire logic irq
);
  import status_reporter_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // stop command decode
  wire stop_cmd = wr && addr == OFS_CMD && wdata[1:0] == CMD_STOP;
  wire stop_ok = stop_cmd && dma_busy && !autoreload_dma_mode;
  // stop handling
  stop_pulse_a: assert property (stop_ok |=> dma_stop)
    else $error("stop of a continuous transfer not answered");
  stop_refuse_a: assert property (stop_cmd && !stop_ok |=> !dma_stop)
    else $error("stop pulse without a continuous transfer");
  stop_cause_a: assert property (dma_stop |-> $past(stop_ok))
    else $error("stop pulse without a stop command");
  // service request output only as peripheral
  srq_gate_a: assert property ($past(ctrl_active) |-> !srq_request)
    else $error("service request raised in controller role");
  // fixed record characters
  mode_char_a: assert property (rd && addr == 8'h81 |=> rdata inside {16'h0043, 16'h0050})
    else $error("mode column not C or P");
  col_space_a: assert property (rd && addr inside {8'h82, 8'h85, 8'h88, 8'h8A, 8'h8D,
    8'h91, 8'h94, 8'h97, 8'h9A} |=> rdata == 16'h0020)
    else $error("separator column not a space");
  err_letter_a: assert property (rd && addr == 8'h8E |=> rdata == 16'h0045)
    else $error("error field does not start with E");
  xfer_letter_a: assert property (rd && addr == 8'h98 |=> rdata == 16'h0050)
    else $error("transfer field does not start with P");
  addr_digit_a: assert property (rd && addr == 8'h83 |=> rdata inside {[16'h0030:16'h0033]})
    else $error("address tens digit out of range");
  // main scenarios
  stop_seen_c: cover property (stop_ok ##1 dma_stop);
  irq_up_c: cover property ($rose(irq));
  srq_up_c: cover property ($rose(srq_request));
endmodule // status_reporter_monitor
bind status_string_reporter status_reporter_monitor u_mon (.clk, .nrst, .addr, .wdata, .wr,
  .rd, .rdata, .ctrl_active, .dma_busy, .autoreload_dma_mode, .dma_stop, .srq_request, .irq);

/* File: dma_engine_model.sv */
// dma_engine_model: far-side dma engine, one character a cycle
// assumes start pulses from the bench and the stop pulse of the reporter
`timescale 1ns/1ns
module dma_engine_model (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // bench control
  input wire logic start,
  input wire logic auto_mode,
  input wire logic hold,
  input wire logic [15:0] len,
  // reporter side
  input wire logic dma_stop,
  output logic dma_busy,
  output logic autoreload_dma_mode,
  output logic [15:0] dma_count
);
  // counts while not held; a stop ends only a continuous run
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dma_busy <= 1'b0;
      autoreload_dma_mode <= 1'b0;
      dma_count <= 16'h0000;
    end else if (start) begin
      dma_busy <= 1'b1;
      autoreload_dma_mode <= auto_mode;
      dma_count <= 16'h0000;
    end else if (dma_busy && dma_stop && !autoreload_dma_mode) begin
      dma_busy <= 1'b0;
    end else if (dma_busy && !hold) begin
      dma_count <= dma_count + 16'h0001;
      dma_busy <= dma_count + 16'h0001 != len;
    end
  end
endmodule // dma_engine_model

/* File: tb_top.sv */
// tb_top: self-checking bench of the status reporter
// assumes the reporter package, the dma model and the bound monitor
`timescale 1ns/1ns
module tb_top;
  import status_reporter_pkg::*;
  typedef struct {string name; logic [15:0] val;} exp_t;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 16'h0000;
  logic wr = 1'b0, rd = 1'b0, rd_q = 1'b0, ctrl_active = 1'b0, talking = 1'b0;
  logic listening = 1'b0, srq_pin = 1'b0, serial_poll_done = 1'b0, trigger_rcvd = 1'b0;
  logic clear_rcvd = 1'b0, start = 1'b0, auto_mode = 1'b0, hold = 1'b0;
  logic [6:0] error_code = 7'h00;
  logic [15:0] len = 16'h0004;
  logic [15:0] rdata, dma_count, held;
  logic dma_busy, autoreload_dma_mode, dma_stop, srq_request, irq;
  logic [7:0] seed = 8'h35;
  int miscompares = 0, n_compared = 0;
  exp_t exp_q[$];

  always #10 clk = ~clk;

  status_string_reporter u_dut (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .ctrl_active,
    .talking, .listening, .srq_pin, .serial_poll_done, .trigger_rcvd, .clear_rcvd,
    .error_code, .dma_busy, .autoreload_dma_mode, .dma_count, .dma_stop, .srq_request, .irq);
  dma_engine_model u_dma (.clk, .nrst, .start, .auto_mode, .hold, .len, .dma_stop,
    .dma_busy, .autoreload_dma_mode, .dma_count);

  task automatic check(string n, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic finish_test;
    if (miscompares == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] lfsr(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // one-cycle register write
  task automatic wr_reg(logic [7:0] a, logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // one-cycle read, expected answer noted for the watcher
  task automatic rd_exp(string n, logic [7:0] a, logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back('{n, e});
    @(posedge clk);
    rd <= 1'b0;
  endtask

  // fresh snapshot, then read a field from its first column
  task automatic fld(int col, string s);
    wr_reg(OFS_CMD, 16'(CMD_STATUS));
    for (int i = 0; i < s.len(); i++) begin
      rd_exp("record", OFS_RECORD + 8'(col + i), 16'(s[i]));
    end
  endtask

  // whole record, padded with spaces
  task automatic rec(string s);
    while (s.len() < REC_LEN) s = {s, " "};
    fld(1, s);
  endtask

  // bus event pulses
  task automatic ev(logic t, logic c, logic p);
    @(posedge clk);
    trigger_rcvd <= t;
    clear_rcvd <= c;
    serial_poll_done <= p;
    @(posedge clk);
    trigger_rcvd <= 1'b0;
    clear_rcvd <= 1'b0;
    serial_poll_done <= 1'b0;
  endtask

  // start a dma run of the given length and mode
  task automatic go(logic [15:0] n, logic m);
    len <= n;
    auto_mode <= m;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask

  // compare each read answer with the oldest note
  always @(posedge clk) begin
    rd_q <= rd;
    if (rd_q && exp_q.size() > 0) begin
      check(exp_q[0].name, rdata, exp_q[0].val);
      void'(exp_q.pop_front());
    end
  end

  // cut a hang short
  initial begin
    repeat (6000) @(posedge clk);
    miscompares++;
    finish_test();
  end

  initial begin
    int a;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rec("P 00 G0 I S0 E00 T0 C0 P0 NO ERROR");
    // bus address from the lfsr, 31 first to hit the limit
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      a = (i == 0) ? 31 : int'(seed[4:0]);
      wr_reg(OFS_CTRL, 16'(a));
      a = (a > 30) ? 30 : a;
      rd_exp("bus address", OFS_CTRL, 16'(a));
      fld(3, $sformatf("%02d", a));
    end
    // controller role, talking, error reported
    wr_reg(OFS_CTRL, 16'h0005);
    ctrl_active <= 1'b1;
    talking <= 1'b1;
    error_code <= 7'h2A;
    rec("C 05 G1 T S0 E42 T0 C0 P0 ERROR");
    talking <= 1'b0;
    listening <= 1'b1;
    fld(9, "L");
    fld(6, "G0");
    // service request in controller role, poll and rearm
    srq_pin <= 1'b1;
    repeat (5) @(posedge clk);
    fld(11, "S1");
    ev(1'b0, 1'b0, 1'b1);
    fld(11, "S0");
    repeat (60) @(posedge clk);
    fld(11, "S1");
    srq_pin <= 1'b0;
    ev(1'b0, 1'b0, 1'b1);
    fld(11, "S0");
    // peripheral request and poll
    ctrl_active <= 1'b0;
    listening <= 1'b0;
    error_code <= 7'h00;
    wr_reg(OFS_CMD, 16'(CMD_REQUEST));
    repeat (2) @(posedge clk);
    check("srq_request", 16'(srq_request), 16'h0001);
    fld(11, "S1");
    ev(1'b0, 1'b0, 1'b1);
    repeat (2) @(posedge clk);
    check("srq_request", 16'(srq_request), 16'h0000);
    // trigger and clear as peripheral
    ev(1'b1, 1'b1, 1'b0);
    fld(18, "T1 C1");
    fld(18, "T0 C0");
    // continuous transfer freezes flags, stop halts it
    go(16'h0100, 1'b0);
    ev(1'b1, 1'b1, 1'b0);
    fld(18, "T0 C0 P1");
    hold <= 1'b1;
    repeat (2) @(posedge clk);
    held = dma_count;
    wr_reg(OFS_CMD, 16'(CMD_STOP));
    rd_exp("count", OFS_XFER_COUNT, held);
    fld(24, "P0");
    hold <= 1'b0;
    // stop after a finished transfer is ignored
    go(16'h0004, 1'b0);
    repeat (10) @(posedge clk);
    wr_reg(OFS_CMD, 16'(CMD_STOP));
    rd_exp("count", OFS_XFER_COUNT, held);
    // autoreload transfer ignores stop
    go(16'h0100, 1'b1);
    wr_reg(OFS_CMD, 16'(CMD_STOP));
    fld(24, "P2");
    repeat (260) @(posedge clk);
    // interrupt raised, masked, cleared
    wr_reg(OFS_IRQ_STAT, 16'h001F);
    wr_reg(OFS_IRQ_MASK, 16'h0004);
    ev(1'b1, 1'b0, 1'b0);
    repeat (2) @(posedge clk);
    check("irq", 16'(irq), 16'h0001);
    rd_exp("irq status", OFS_IRQ_STAT, 16'h0004);
    wr_reg(OFS_IRQ_MASK, 16'h0000);
    repeat (2) @(posedge clk);
    check("irq", 16'(irq), 16'h0000);
    wr_reg(OFS_IRQ_MASK, 16'h0004);
    repeat (2) @(posedge clk);
    check("irq", 16'(irq), 16'h0001);
    wr_reg(OFS_IRQ_STAT, 16'h0004);
    repeat (2) @(posedge clk);
    check("irq", 16'(irq), 16'h0000);
    rd_exp("unmapped", 8'h20, 16'h0000);
    repeat (4) @(posedge clk);
    finish_test();
  end
endmodule // tb_top
